// ### verilog/iox_port_ctrl.v
`default_nettype none
`include "iox_defines.vh"

// How it works
// - Each port set input or output by mode
// - Inputs give level, pulses, period, high time
// - Enabled input changes raise host interrupt
// - Code 1 drives low, code 2 high
// - Code 3 switch input, 3.17 ms debounce
// - Code 4 plain input, interrupt enabled
// - Code 5 switch input, interrupt enabled
// - Command codes split into result, source, none
module iox_port_ctrl #(
  parameter DB_CYC = (`IOX_DB_TIME_NS * `IOX_CLK_MHZ + 999) / 1000,
  parameter DBW    = 15,  // Wide enough for DB_CYC
  parameter CW     = 16,  // Measurement counter width
  parameter AW     = 8    // Register address width
) (
  input  wire          ref_clk,
  input  wire          rst_b,
  input  wire [AW-1:0] s_axi_awaddr,
  input  wire          s_axi_awvalid,
  output wire          s_axi_awready,
  input  wire [31:0]   s_axi_wdata,
  input  wire [3:0]    s_axi_wstrb,
  input  wire          s_axi_wvalid,
  output wire          s_axi_wready,
  output reg  [1:0]    s_axi_bresp,
  output reg           s_axi_bvalid,
  input  wire          s_axi_bready,
  input  wire [AW-1:0] s_axi_araddr,
  input  wire          s_axi_arvalid,
  output wire          s_axi_arready,
  output reg  [31:0]   s_axi_rdata,
  output reg  [1:0]    s_axi_rresp,
  output reg           s_axi_rvalid,
  input  wire          s_axi_rready,
  input  wire [15:0]   port_in,
  output wire [15:0]   port_out,
  output wire [15:0]   port_oe_b,
  output wire          irq
);

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  reg  [1:0] rst_pipe;     // Two-stage release
  wire       rst_sync_b;   // Released copy for the block

  // Assert at once, release after two edges
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_sync_b = rst_pipe[1];

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  reg           aw_held;     // Write address captured
  reg           w_held;      // Write data captured
  reg  [AW-1:0] aw_addr;     // Captured write address
  reg  [31:0]   w_data;      // Captured write data
  reg  [3:0]    w_strb;      // Captured byte enables
  reg  [3:0]    own_addr;    // This module's bus address
  reg  [6:0]    last_cmd;    // Last accepted command code
  reg  [1:0]    cmd_class;   // Class of that command
  reg  [15:0]   chg_stat;    // Sticky change flags
  reg  [15:0]   chg_mask;    // Interrupt enables
  reg  [3:0]    sel;         // Port chosen for readback
  reg  [15:0]   cnt_clr;     // One-cycle count clears
  reg  [31:0]   rd_word;     // Read mux output
  reg           rd_known;    // Read address is mapped
  reg           wr_known;    // Write address is mapped

  wire [63:0]   port_mode;   // Applied code per port
  wire [15:0]   level_all;   // Filtered levels
  wire [15:0]   change_all;  // Accepted level changes
  wire [15:0]   irq_en;      // Port raises interrupts
  wire [15:0]   db_en;       // Port uses the filter
  wire [16*CW-1:0] cnt_all;  // Pulse counts
  wire [16*CW-1:0] per_all;  // Periods
  wire [16*CW-1:0] hi_all;   // High times

  wire wr_go  = aw_held && w_held;
  wire rd_go  = s_axi_arvalid && s_axi_arready;
  // Host selects this module by address
  wire tgt_ok = (w_data[`IOX_TGT_LSB+3:`IOX_TGT_LSB] == own_addr);

  // ----------------------------------------
  // Command classification
  // ----------------------------------------
  function [1:0] class_of;
    input [6:0] code;
    begin
      if ((code != 7'h00 && code <= `IOX_CMD_RES_HI) ||
          code == `IOX_CMD_RES_A || code == `IOX_CMD_RES_B ||
          code == `IOX_CMD_RES_C) begin
        class_of = `IOX_CLS_RESULT;
      end else if ((code >= `IOX_CMD_SRC_LO &&
                    code <= `IOX_CMD_SRC_HI) ||
                   (code >= `IOX_CMD_SRC2_LO &&
                    code <= `IOX_CMD_SRC2_HI)) begin
        class_of = `IOX_CLS_SOURCE;
      end else begin
        class_of = `IOX_CLS_NONE;
      end
    end
  endfunction

  // ----------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------
  // One write at a time; no new beat while a response waits
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;

  // Address map check for writes
  always @* begin
    case (aw_addr)
      `IOX_OFS_OWN_ADDR, `IOX_OFS_CMD,
      `IOX_OFS_MODE_G0, `IOX_OFS_MODE_G1,
      `IOX_OFS_MODE_G2, `IOX_OFS_MODE_G3,
      `IOX_OFS_LEVEL, `IOX_OFS_CHG_STAT,
      `IOX_OFS_CHG_MASK, `IOX_OFS_SEL,
      `IOX_OFS_COUNT, `IOX_OFS_PERIOD,
      `IOX_OFS_HIGH, `IOX_OFS_CNT_CLR: wr_known = 1'b1;
      default: wr_known = 1'b0;
    endcase
  end

  // Capture address and data in either order
  always @(posedge ref_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_addr      <= {AW{1'b0}};
      w_data       <= 32'h0000_0000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `IOX_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (wr_go) begin
        w_held <= 1'b0;
      end
      // Response follows both halves
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_known ? `IOX_RESP_OKAY : `IOX_RESP_DECERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  // Read-only offsets take writes silently
  always @(posedge ref_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      own_addr  <= `IOX_ADDR_RST;
      last_cmd  <= 7'h00;
      cmd_class <= `IOX_CLS_NONE;
      chg_mask  <= 16'h0000;
      sel       <= 4'h0;
      cnt_clr   <= 16'h0000;
    end else begin
      cnt_clr <= 16'h0000;
      if (wr_go) begin
        case (aw_addr)
          `IOX_OFS_OWN_ADDR: begin
            // Addresses above 14 are not legal; keep old one
            if (w_strb[0] && w_data[3:0] <= `IOX_ADDR_MAX) begin
              own_addr <= w_data[3:0];
            end
          end
          `IOX_OFS_CMD: begin
            if (tgt_ok && w_strb[0]) begin
              last_cmd  <= w_data[6:0];
              cmd_class <= class_of(w_data[6:0]);
            end
          end
          `IOX_OFS_CHG_MASK: begin
            if (w_strb[0]) begin
              chg_mask[7:0] <= w_data[7:0];
            end
            if (w_strb[1]) begin
              chg_mask[15:8] <= w_data[15:8];
            end
          end
          `IOX_OFS_SEL: begin
            if (w_strb[0]) begin
              sel <= w_data[3:0];
            end
          end
          `IOX_OFS_CNT_CLR: begin
            cnt_clr <= {w_strb[1] ? w_data[15:8] : 8'h00,
                        w_strb[0] ? w_data[7:0]  : 8'h00};
          end
          default: begin
            // Other offsets handled elsewhere
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // Per-port mode and input channel
  // ----------------------------------------
  genvar p;
  generate
    for (p = 0; p < 16; p = p + 1) begin : g_port
      reg  [3:0] mode;      // Applied code
      reg        drv_hi;    // Output level
      reg        drv_off;   // Pin released
      reg  [3:0] next_mode;
      // Group g covers ports 4g..4g+3
      wire grp_wr = wr_go && tgt_ok && w_strb[2] &&
                    w_strb[(p % 4) / 2] &&
                    aw_addr == `IOX_OFS_MODE_G0 + 8'h04 * (p / 4);
      wire [3:0] code = w_data[4*(p%4) +: 4];

      // Only codes 1 to 5 change the port
      always @* begin
        next_mode = mode;
        if (grp_wr) begin  // Foreign address never gets here
          case (code)
            `IOX_MODE_LOW, `IOX_MODE_HIGH, `IOX_MODE_SW_DB,
            `IOX_MODE_DIG_IRQ, `IOX_MODE_SW_IRQ: next_mode = code;
            default: next_mode = mode;  // 0 and 6-15
          endcase
        end
      end

      // Mode and pin drive update together
      always @(posedge ref_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
          mode    <= `IOX_MODE_RST;
          drv_hi  <= 1'b0;
          drv_off <= 1'b1;
        end else begin
          mode    <= next_mode;
          drv_hi  <= (next_mode == `IOX_MODE_HIGH);
          drv_off <= !(next_mode == `IOX_MODE_LOW ||
                       next_mode == `IOX_MODE_HIGH);
        end
      end

      assign port_mode[4*p +: 4] = mode;
      assign port_out[p]         = drv_hi;
      assign port_oe_b[p]        = drv_off;
      // Switch closure modes filter
      assign db_en[p]  = (mode == `IOX_MODE_SW_DB) ||
                         (mode == `IOX_MODE_SW_IRQ);
      // Interrupting modes
      assign irq_en[p] = (mode == `IOX_MODE_DIG_IRQ) ||
                         (mode == `IOX_MODE_SW_IRQ);

      iox_chan #(
        .DB_CYC (DB_CYC),
        .DBW    (DBW),
        .CW     (CW)
      ) u_chan (
        .clk       (ref_clk),
        .rst_n     (rst_sync_b),
        .pin       (port_in[p]),
        .db_en     (db_en[p]),
        .cnt_clr   (cnt_clr[p]),
        .level     (level_all[p]),
        .change    (change_all[p]),
        .count     (cnt_all[CW*p +: CW]),
        .period    (per_all[CW*p +: CW]),
        .high_time (hi_all[CW*p +: CW])
      );
    end
  endgenerate

  // ----------------------------------------
  // Change flags and interrupt
  // ----------------------------------------
  // Read of the status clears it; a new change in
  // the same cycle survives the clear
  always @(posedge ref_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      chg_stat <= 16'h0000;
    end else begin
      chg_stat <= ((rd_go && s_axi_araddr == `IOX_OFS_CHG_STAT) ?
                   16'h0000 : chg_stat) |
                  (change_all & irq_en);
    end
  end

  // Level output while any unmasked flag stands
  assign irq = |(chg_stat & chg_mask);

  // ----------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------
  assign s_axi_arready = !s_axi_rvalid;

  // Read mux; selected port picked by index
  always @* begin
    rd_word  = 32'h0000_0000;
    rd_known = 1'b1;
    case (s_axi_araddr)
      `IOX_OFS_OWN_ADDR: rd_word[3:0] = own_addr;
      `IOX_OFS_CMD: begin
        rd_word[6:0] = last_cmd;
        rd_word[9:8] = cmd_class;
      end
      `IOX_OFS_MODE_G0: rd_word[15:0] = port_mode[15:0];
      `IOX_OFS_MODE_G1: rd_word[15:0] = port_mode[31:16];
      `IOX_OFS_MODE_G2: rd_word[15:0] = port_mode[47:32];
      `IOX_OFS_MODE_G3: rd_word[15:0] = port_mode[63:48];
      `IOX_OFS_LEVEL:    rd_word[15:0] = level_all;
      `IOX_OFS_CHG_STAT: rd_word[15:0] = chg_stat;
      `IOX_OFS_CHG_MASK: rd_word[15:0] = chg_mask;
      `IOX_OFS_SEL:      rd_word[3:0]  = sel;
      `IOX_OFS_COUNT:    rd_word[CW-1:0] = cnt_all[CW*sel +: CW];
      `IOX_OFS_PERIOD:   rd_word[CW-1:0] = per_all[CW*sel +: CW];
      `IOX_OFS_HIGH:     rd_word[CW-1:0] = hi_all[CW*sel +: CW];
      `IOX_OFS_CNT_CLR:  rd_word = 32'h0000_0000;
      default: rd_known = 1'b0;  // Unmapped reads zero
    endcase
  end

  // Data registered one edge after the address
  always @(posedge ref_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `IOX_RESP_OKAY;
    end else begin
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= rd_known ? `IOX_RESP_OKAY : `IOX_RESP_DECERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // iox_port_ctrl
`default_nettype wire

// ### pkg/iox_defines.vh
`ifndef IOX_DEFINES_VH
`define IOX_DEFINES_VH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define IOX_OFS_OWN_ADDR  8'h00
`define IOX_OFS_CMD       8'h04
`define IOX_OFS_MODE_G0   8'h08
`define IOX_OFS_MODE_G1   8'h0C
`define IOX_OFS_MODE_G2   8'h10
`define IOX_OFS_MODE_G3   8'h14
`define IOX_OFS_LEVEL     8'h18
`define IOX_OFS_CHG_STAT  8'h1C
`define IOX_OFS_CHG_MASK  8'h20
`define IOX_OFS_SEL       8'h24
`define IOX_OFS_COUNT     8'h28
`define IOX_OFS_PERIOD    8'h2C
`define IOX_OFS_HIGH      8'h30
`define IOX_OFS_CNT_CLR   8'h34
// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define IOX_TGT_LSB       16
`define IOX_ADDR_RST      4'h0
`define IOX_ADDR_MAX      4'hE
`define IOX_MODE_RST      4'h3
// ----------------------------------------
// Port mode codes
// ----------------------------------------
`define IOX_MODE_LOW      4'h1
`define IOX_MODE_HIGH     4'h2
`define IOX_MODE_SW_DB    4'h3
`define IOX_MODE_DIG_IRQ  4'h4
`define IOX_MODE_SW_IRQ   4'h5
// ----------------------------------------
// Command code classes
// ----------------------------------------
`define IOX_CLS_NONE      2'h0
`define IOX_CLS_RESULT    2'h1
`define IOX_CLS_SOURCE    2'h2
`define IOX_CMD_RES_HI    7'h45
`define IOX_CMD_SRC_LO    7'h46
`define IOX_CMD_SRC_HI    7'h55
`define IOX_CMD_RES_A     7'h5B
`define IOX_CMD_RES_B     7'h5C
`define IOX_CMD_SRC2_LO   7'h5D
`define IOX_CMD_SRC2_HI   7'h62
`define IOX_CMD_RES_C     7'h63
// ----------------------------------------
// Bus answers and timing
// ----------------------------------------
`define IOX_RESP_OKAY     2'h0
`define IOX_RESP_DECERR   2'h3
`define IOX_DB_TIME_NS    3170000
`define IOX_CLK_MHZ       10
`endif

// ### verilog/iox_chan.v
`default_nettype none
`include "iox_defines.vh"

// ----------------------------------------
// One port's input conditioning
// ----------------------------------------
module iox_chan #(
  parameter DB_CYC = 31700,  // Debounce length in cycles
  parameter DBW    = 15,     // Debounce counter width
  parameter CW     = 16      // Measurement counter width
) (
  input  wire          clk,
  input  wire          rst_n,
  input  wire          pin,
  input  wire          db_en,
  input  wire          cnt_clr,
  output reg           level,
  output reg           change,
  output reg  [CW-1:0] count,
  output reg  [CW-1:0] period,
  output reg  [CW-1:0] high_time
);

  localparam integer   DB_LAST_I = DB_CYC - 1;  // Full-width last count
  localparam [DBW-1:0] DB_LAST   = DB_LAST_I[DBW-1:0];
  localparam [CW-1:0]  CMAX    = {CW{1'b1}};

  reg  [DBW-1:0] db_cnt;     // Cycles the pin has differed
  reg  [CW-1:0]  per_acc;    // Cycles since last rising edge
  reg  [CW-1:0]  hi_acc;     // High cycles since last rise
  reg            seen_rise;  // A first rise has been seen

  // Pin differs from the accepted level
  wire differ = (pin != level);
  // Debounced ports wait the full filter time
  wire accept = differ && (!db_en || db_cnt == DB_LAST);
  wire rise   = accept && !level;

  // ----------------------------------------
  // Filter, counter and period capture
  // ----------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      level     <= 1'b0;
      change    <= 1'b0;
      db_cnt    <= {DBW{1'b0}};
      count     <= {CW{1'b0}};
      per_acc   <= {CW{1'b0}};
      hi_acc    <= {CW{1'b0}};
      period    <= {CW{1'b0}};
      high_time <= {CW{1'b0}};
      seen_rise <= 1'b0;
    end else begin
      change <= accept;  // Level and change step together
      // A bounce back restarts the filter
      if (!differ || accept) begin
        db_cnt <= {DBW{1'b0}};
      end else begin
        db_cnt <= db_cnt + 1'b1;
      end
      if (accept) begin
        level <= pin;  // Present logic level
      end
      // Pulse count saturates; clear wins over a rise
      if (cnt_clr) begin
        count <= {CW{1'b0}};
      end else if (rise && count != CMAX) begin
        count <= count + 1'b1;
      end
      // Period and high time close on each rise after the first
      if (rise) begin
        per_acc   <= {CW{1'b0}};
        hi_acc    <= {CW{1'b0}};
        seen_rise <= 1'b1;
        if (seen_rise) begin
          period    <= (per_acc == CMAX) ? CMAX : per_acc + 1'b1;
          high_time <= hi_acc;  // Duty cycle numerator
        end
      end else begin
        if (per_acc != CMAX) begin
          per_acc <= per_acc + 1'b1;
        end
        if (level && hi_acc != CMAX) begin
          hi_acc <= hi_acc + 1'b1;
        end
      end
    end
  end

endmodule // iox_chan
`default_nettype wire

// ### verif/iox_port_ctrl_asserts.sv
`default_nettype none
`include "iox_defines.vh"
// ----------------------------------------
// Port and bus behaviour checks
// ----------------------------------------
module iox_port_ctrl_asserts (
  input wire logic        ref_clk,
  input wire logic        rst_b,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [15:0] port_out,
  input wire logic [15:0] port_oe_b,
  input wire logic        irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb_chk @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);

  // A released port never shows a high drive
  property p_drive_oe; (port_out & port_oe_b) == 16'h0000; endproperty
  // Pins move only with a write answer, never on their own
  property p_pins_at_wr;
    !$stable({port_out, port_oe_b}) |-> $rose(s_axi_bvalid);
  endproperty
  // Interrupt drops only after an accepted read or with a write answer
  property p_irq_fall;
    $fell(irq) |-> $past(s_axi_arvalid && s_axi_arready) ||
                   $rose(s_axi_bvalid);
  endproperty
  property p_r_lat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  property p_r_cause;
    $rose(s_axi_rvalid) |-> $past(s_axi_arvalid && s_axi_arready);
  endproperty
  property p_ar_refuse; s_axi_rvalid |-> !s_axi_arready; endproperty
  property p_b_refuse;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  property p_err_data;
    s_axi_rvalid && s_axi_rresp == `IOX_RESP_DECERR |-> s_axi_rdata == 32'h0;
  endproperty
  property p_b_drop; $fell(s_axi_bvalid) |-> $past(s_axi_bready); endproperty

  a_drive_oe: assert property (p_drive_oe)
    else $error("port driven high while released");
  a_pins_at_wr: assert property (p_pins_at_wr)
    else $error("port drive changed without a write");
  a_irq_fall: assert property (p_irq_fall)
    else $error("interrupt dropped without a cause");
  a_r_lat: assert property (p_r_lat)
    else $error("read answer late");
  a_r_cause: assert property (p_r_cause)
    else $error("read answer without request");
  a_ar_refuse: assert property (p_ar_refuse)
    else $error("read taken while answer pending");
  a_b_refuse: assert property (p_b_refuse)
    else $error("write taken while answer pending");
  a_err_data: assert property (p_err_data)
    else $error("error read carries data");
  a_b_drop: assert property (p_b_drop)
    else $error("write answer withdrawn early");

  c_irq: cover property ($rose(irq));
  c_drive: cover property ($fell(port_oe_b[0]));
  c_err: cover property (s_axi_rvalid && s_axi_rresp == `IOX_RESP_DECERR);
endmodule // iox_port_ctrl_asserts

bind iox_port_ctrl iox_port_ctrl_asserts i_chk (
  .ref_clk(ref_clk), .rst_b(rst_b), .s_axi_awready(s_axi_awready),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rresp(s_axi_rresp), .s_axi_rdata(s_axi_rdata),
  .port_out(port_out), .port_oe_b(port_oe_b), .irq(irq)
);
`default_nettype wire

// ### verif/iox_pin_model.sv
`default_nettype none
// ----------------------------------------
// Field wiring on the sixteen ports
// ----------------------------------------
module iox_pin_model (
  input  wire logic [15:0] port_out,
  input  wire logic [15:0] port_oe_b,
  input  wire logic [15:0] ext_level,
  output var  logic [15:0] port_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // Driven ports read back their own drive, released ones the field
  assign port_in = (~port_oe_b & port_out) |
                   (port_oe_b & ext_level);
endmodule // iox_pin_model
`default_nettype wire

// ### verif/tb_iox_port_ctrl.sv
`default_nettype none
`include "iox_defines.vh"
// ----------------------------------------
// Bench for the port mode controller
// ----------------------------------------
module tb_iox_port_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  logic        ref_clk, rst_b;              // Clock, raw reset
  logic [7:0]  s_axi_awaddr, s_axi_araddr;  // Byte addresses
  logic [31:0] s_axi_wdata, s_axi_rdata;    // Bus words
  logic [3:0]  s_axi_wstrb;                 // All lanes on
  logic [1:0]  s_axi_bresp, s_axi_rresp;    // Answer codes
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid, irq;
  logic [15:0] port_in, port_out, port_oe_b, ext_level;
  logic [31:0] rd_data;                     // Last read word
  logic [1:0]  rd_resp;                     // Last read code
  int          n_mismatch, tests_run, status;
  // Command codes around the class boundaries; 00, 5A and 64 left out
  logic [6:0]  codes [10] = '{7'h01, 7'h45, 7'h46, 7'h55, 7'h56,
                              7'h5B, 7'h5C, 7'h5D, 7'h62, 7'h63};

  // Short debounce keeps the run brief
  iox_port_ctrl #(.DB_CYC(4)) i_dut (
    .ref_clk(ref_clk), .rst_b(rst_b), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .port_in(port_in), .port_out(port_out), .port_oe_b(port_oe_b),
    .irq(irq)
  );
  iox_pin_model i_pins (
    .port_out(port_out), .port_oe_b(port_oe_b),
    .ext_level(ext_level), .port_in(port_in)
  );

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk);
  endtask

  // Write: both halves offered at once, each released when taken
  // No cycle limit here: only the hang guard ends a wait
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    // Host bookkeeping: cleared on success, bumped per failure
    status = (s_axi_bresp === `IOX_RESP_OKAY) ? 0 : status + 1;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd_data = s_axi_rdata;
    rd_resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    check(rd_data, exp);
  endtask

  // Expected class of a command code
  function automatic logic [1:0] cls(input logic [6:0] c);
    if ((c >= 7'h01 && c <= 7'h45) || c == 7'h5B || c == 7'h5C || c == 7'h63)
      return 2'h1;
    if ((c >= 7'h46 && c <= 7'h55) || (c >= 7'h5D && c <= 7'h62))
      return 2'h2;
    return 2'h0;
  endfunction

  task automatic stop_test;
    if (n_mismatch == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Hang guard, far beyond the few hundred cycles needed
  initial begin
    #2000000;
    n_mismatch++;
    stop_test();
  end

  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata  = 32'h0;
    s_axi_wstrb  = 4'hF;
    ext_level    = 16'h0000;
    rst_b        = 1'b0;
    n_mismatch   = 0;
    tests_run    = 0;
    status       = 0;
    tick(16);
    rst_b <= 1'b1;
    tick(3);
    // ---------------- Reset state, address ----------------
    check(32'(port_oe_b), 32'h0000FFFF);
    rdc(`IOX_OFS_MODE_G0, 32'h00003333);
    wr(`IOX_OFS_OWN_ADDR, 32'h00000005);
    wr(`IOX_OFS_OWN_ADDR, 32'h0000000F);
    rdc(`IOX_OFS_OWN_ADDR, 32'h00000005);
    // ---------------- Modes per port ----------------
    wr(`IOX_OFS_MODE_G0, 32'h00025421);
    check(32'(port_oe_b), 32'h0000FFFF);
    wr(`IOX_OFS_MODE_G0, 32'h00055421);
    check(32'({port_out[3:0], port_oe_b[3:0]}), 32'h0000002C);
    wr(`IOX_OFS_MODE_G0, 32'h00059976);
    rdc(`IOX_OFS_MODE_G0, 32'h00005421);
    wr(`IOX_OFS_MODE_G3, 32'h00052000);
    check(32'({port_out[15], port_oe_b[15]}), 32'h00000002);
    rdc(`IOX_OFS_MODE_G3, 32'h00002333);
    // ---------------- Change interrupt ----------------
    rd(`IOX_OFS_CHG_STAT);
    wr(`IOX_OFS_CHG_MASK, 32'h0000000C);
    ext_level[2] <= 1'b1;
    tick(4);
    check(32'(irq), 32'h1);
    rdc(`IOX_OFS_CHG_STAT, 32'h4);
    check(32'(irq), 32'h0);
    // A short bounce must be filtered out
    ext_level[3] <= 1'b1;
    tick(2);
    ext_level[3] <= 1'b0;
    tick(8);
    check(32'(irq), 32'h0);
    ext_level[3] <= 1'b1;
    tick(2);
    check(32'(irq), 32'h0);
    tick(6);
    check(32'(irq), 32'h1);
    rdc(`IOX_OFS_CHG_STAT, 32'h8);
    rd(`IOX_OFS_LEVEL);
    check(rd_data & 32'h0000000C, 32'h0000000C);
    wr(`IOX_OFS_CHG_MASK, 32'h0);
    ext_level[2] <= 1'b0;
    tick(4);
    check(32'(irq), 32'h0);
    rdc(`IOX_OFS_CHG_STAT, 32'h4);
    // ---------------- Pulse count and timing ----------------
    wr(`IOX_OFS_SEL, 32'h2);
    wr(`IOX_OFS_CNT_CLR, 32'h4);
    repeat (3) begin
      ext_level[2] <= 1'b1;
      tick(4);
      ext_level[2] <= 1'b0;
      tick(6);
    end
    rdc(`IOX_OFS_COUNT, 32'h3);
    rdc(`IOX_OFS_PERIOD, 32'hA);
    rdc(`IOX_OFS_HIGH, 32'h4);
    // ---------------- Commands and errors ----------------
    foreach (codes[i]) begin
      wr(`IOX_OFS_CMD, 32'h00050000 | 32'(codes[i]));
      rdc(`IOX_OFS_CMD, {22'h0, cls(codes[i]), 1'b0, codes[i]});
    end
    wr(`IOX_OFS_CMD, 32'h00030001);
    rdc(`IOX_OFS_CMD, 32'h00000163);
    rdc(8'h80, 32'h0);
    check(32'(rd_resp), 32'(`IOX_RESP_DECERR));
    wr(8'h84, 32'h0);
    check(32'(status), 32'h1);
    stop_test();
  end
endmodule // tb_iox_port_ctrl
`default_nettype wire
